// ### rtl/adc_irq_regs.sv
// converter interrupt mask, status flags and channel result registers
//
// How it works
// - disable write ones clear mask bits
// - mask read shows enabled interrupt sources
// - bits 0-7 are channel done interrupts
// - bits 8-15 are channel overrun interrupts
// - bit 16 result available, 17 global overrun
// - bit 18 transfer end, 19 buffers empty
// - mask is read-only, same layout
// - result captured at completion, held after
// - result updated only for enabled channels
// - enable write ones set mask bits
// - done flag reads one only if enabled
// - overrun flags cleared by status read
// - result available cleared by latest read
//
// register map, byte offsets; only the low address byte is decoded,
// so the map repeats every 256 bytes
// 0x00 channel enable, ones switch channels on
// 0x04 channel disable, ones switch channels off
// 0x08 channel state, one bit per channel that is on
// 0x0C status word, read clears overrun, global overrun, transfer end
// 0x10 latest result, read clears result available
// 0x14 interrupt enable, ones set mask bits
// 0x18 interrupt disable, ones clear mask bits
// 0x1C interrupt mask, read-only
// 0x20 result of channel 0, channel n at 0x20 + 4n
// other offsets read zero, writes to them are dropped
//
// status and mask layout
// bits 0-7 conversion done, shown only while the channel is on
// bits 8-15 channel overrun, a result landed on an unread one
// bit 16 result available
// bit 17 global overrun, a result landed while one waited
// bit 18 receive transfer end, sticky
// bit 19 receive buffers empty, a live level, not sticky
// bits 20-31 read zero
//
// bus timing
// zero wait states, response always okay
// only whole-word transfers are taken, other sizes are ignored
// a stalled bus holds both phases, nothing is taken meanwhile
// register read data captured at the address phase edge, stand for
// the whole data phase; result words are reread from memory each cycle
// clearing side effects act at that same edge, so a read returns
// the flags that it clears
// a read right behind a write sees the written enable and mask
// an event in the clearing cycle survives the clear
//
// conversion port
// a completion is taken only for a channel that is on;
// a completion for a channel that is off changes nothing
// at most one completion per cycle
// done, overrun and result flags show from the next cycle
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module adc_irq_regs
    import adc_irq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // conversion core
    input wire logic conv_done,
    input wire logic [CHAN_W-1:0] conv_channel,
    input wire logic [DATA_W-1:0] conv_value,
    input wire logic rx_count_zero,
    input wire logic rx_buffers_empty,
    output logic [CHAN_N-1:0] chan_enabled,
    // interrupt
    output logic adc_irq
);

    // bus phase tracking
    logic addr_valid;
    logic [DEC_W-1:0] addr_ofs;
    logic wr_pending;
    logic [DEC_W-1:0] wr_ofs;
    logic rd_result;
    logic [31:0] rd_word;

    // control and status state
    logic [IRQ_W-1:0] irq_mask;
    logic [DATA_W-1:0] latest_value;
    logic [CHAN_N-1:0] done_flags;
    logic result_available_flag_flag;
    logic [CHAN_N-1:0] channel_overrun_flag_flags;
    logic global_overrun_flag_flag;
    logic receive_transfer_end_flag_flag;
    logic [IRQ_W-1:0] status_word;

    // read side effects, taken in the address phase
    logic rd_status;
    logic rd_latest;
    logic [CHAN_N-1:0] rd_chan_clear;

    // write strobes, taken in the data phase
    logic wr_chan_en;
    logic wr_chan_dis;
    logic wr_irq_en;
    logic wr_irq_dis;

    // conversion events
    logic conv_accept;
    logic [CHAN_N-1:0] conv_onehot;
    logic [CHAN_N-1:0] channel_overrun_flag_set;
    logic global_overrun_flag_set;

    logic [DATA_W-1:0] mem_rd_data;

    // next values of the written state, also used by the read mux
    logic [CHAN_N-1:0] next_chan_enabled;
    logic [IRQ_W-1:0] next_irq_mask;

    // address phase read selects
    logic rd_take;
    logic rd_sel_chan;
    logic rd_sel_mask;

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // only whole-word transfers are taken, nonsequential or sequential
    assign addr_valid = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
    assign addr_ofs = haddr[DEC_W-1:0];

    // hold the write address until its data arrives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_ofs <= '0;
        end else if (hready) begin
            wr_pending <= addr_valid && hwrite;
            wr_ofs <= addr_ofs;
        end
    end

    // data-phase write strobes
    assign wr_chan_en = wr_pending && (wr_ofs == CHAN_ENABLE_OFS);
    assign wr_chan_dis = wr_pending && (wr_ofs == CHAN_DISABLE_OFS);
    assign wr_irq_en = wr_pending && (wr_ofs == IRQ_ENABLE_OFS);
    assign wr_irq_dis = wr_pending && (wr_ofs == IRQ_DISABLE_OFS);

    // channel enable state, set and clear by separate words
    always_comb begin
        next_chan_enabled = chan_enabled;
        if (wr_chan_en) begin
            next_chan_enabled = next_chan_enabled | hwdata[CHAN_N-1:0];
        end
        if (wr_chan_dis) begin
            next_chan_enabled = next_chan_enabled & ~hwdata[CHAN_N-1:0];
        end
    end

    // all channels off out of reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_enabled <= CHAN_EN_RESET;
        end else begin
            chan_enabled <= next_chan_enabled;
        end
    end

    // interrupt mask; enable ones set, disable ones clear, zeros ignored
    // no write path from the mask offset
    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_irq_en) begin
            next_irq_mask = next_irq_mask | hwdata[IRQ_W-1:0];
        end
        if (wr_irq_dis) begin
            next_irq_mask = next_irq_mask & ~hwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= IRQ_MASK_RESET;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    // read selects and side effects, decoded once from the address phase
    assign rd_take = addr_valid && !hwrite;
    assign rd_sel_chan = rd_take && (addr_ofs == CHAN_STATUS_OFS);
    assign rd_status = rd_take && (addr_ofs == STATUS_OFS);
    assign rd_latest = rd_take && (addr_ofs == LATEST_OFS);
    assign rd_sel_mask = rd_take && (addr_ofs == IRQ_MASK_OFS);

    // reading a channel result consumes its done flag
    always_comb begin
        rd_chan_clear = '0;
        if (rd_take && is_result_addr(addr_ofs)) begin
            rd_chan_clear[result_index(addr_ofs)] = 1'b1;
        end
    end

    // conversions on disabled channels are dropped entirely
    // enabled channels only
    assign conv_accept = conv_done && chan_enabled[conv_channel];

    always_comb begin
        conv_onehot = '0;
        if (conv_accept) begin
            conv_onehot[conv_channel] = 1'b1;
        end
    end

    // overrun: a new result lands on an unread one
    generate
        for (genvar c = 0; c < CHAN_N; c++) begin : g_channel_overrun_flag
            assign channel_overrun_flag_set[c] = conv_onehot[c] && done_flags[c];
        end
    endgenerate

    // global overrun: latest result overwritten before it was read
    assign global_overrun_flag_set = conv_accept && result_available_flag_flag;

    // done flags per channel, cleared by reading that channel's result
    sticky_flags #(
        .W(CHAN_N)
    ) u_done_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(conv_onehot),
        .clr(rd_chan_clear),
        .flags(done_flags)
    );

    sticky_flags #(
        .W(1)
    ) u_result_available_flag_flag (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(conv_accept),
        .clr(rd_latest),
        .flags(result_available_flag_flag)
    );

    // overrun flags cleared by status read
    sticky_flags #(
        .W(CHAN_N + 2)
    ) u_err_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .set({rx_count_zero, global_overrun_flag_set, channel_overrun_flag_set}),
        .clr({(CHAN_N + 2){rd_status}}),
        .flags({receive_transfer_end_flag_flag, global_overrun_flag_flag, channel_overrun_flag_flags})
    );

    // latest result follows every accepted conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latest_value <= DATA_RESET;
        end else if (conv_accept) begin
            latest_value <= conv_value;
        end
    end

    // per-channel results, held until the channel converts again
    // capture and hold
    result_memory u_results (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(conv_accept),
        .wr_addr(conv_channel),
        .wr_data(conv_value),
        .rd_addr(result_index(addr_ofs)),
        .rd_data(mem_rd_data)
    );

    // status word in the shared bit layout
    // done bits 0-7
    // bits 18 and 19, upper bits zero
    always_comb begin
        status_word = '0;
        status_word[EOC_LSB +: CHAN_N] = done_flags & chan_enabled;
        status_word[CHANNEL_OVERRUN_FLAG_LSB +: CHAN_N] = channel_overrun_flag_flags;
        status_word[RESULT_AVAILABLE_FLAG_BIT] = result_available_flag_flag;
        status_word[GLOBAL_OVERRUN_FLAG_BIT] = global_overrun_flag_flag;
        status_word[RECEIVE_TRANSFER_END_FLAG_BIT] = receive_transfer_end_flag_flag;
        status_word[RECEIVE_BUFFERS_EMPTY_FLAG_BIT] = rx_buffers_empty;
    end

    // level interrupt from any unmasked status bit
    // irq from flags and mask
    assign adc_irq = |(status_word & irq_mask);

    // which source drives the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_result <= 1'b0;
        end else if (hready) begin
            rd_result <= rd_take && is_result_addr(addr_ofs);
        end
    end

    // register read data, captured in the address phase so a clearing
    // read still returns the flags it clears; enable state and mask come
    // from their next values so a read right behind a write sees it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_word <= '0;
        end else if (hready) begin
            if (rd_sel_chan) begin
                rd_word <= {{(32 - CHAN_N){1'b0}}, next_chan_enabled};
            end else if (rd_status) begin
                rd_word <= {{(32 - IRQ_W){1'b0}}, status_word};
            end else if (rd_latest) begin
                rd_word <= {{(32 - DATA_W){1'b0}}, latest_value};
            end else if (rd_sel_mask) begin
                rd_word <= {{(32 - IRQ_W){1'b0}}, next_irq_mask};
            end else begin
                rd_word <= '0;
            end
        end
    end

    // result words come straight from the memory's output register
    // ten data bits, rest zero
    assign hrdata = rd_result ? {{(32 - DATA_W){1'b0}}, mem_rd_data}
                              : rd_word;

endmodule : adc_irq_regs

// ### shared/adc_irq_pkg.sv
// constants for the converter interrupt mask and channel result registers
package adc_irq_pkg;

    // widths
    localparam int CHAN_N = 8;
    localparam int CHAN_W = 3;
    localparam int DATA_W = 10;
    localparam int IRQ_W = 20;
    localparam int DEC_W = 8;

    // register byte offsets
    localparam logic [7:0] CHAN_ENABLE_OFS = 8'h00;
    localparam logic [7:0] CHAN_DISABLE_OFS = 8'h04;
    localparam logic [7:0] CHAN_STATUS_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] LATEST_OFS = 8'h10;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h14;
    localparam logic [7:0] IRQ_DISABLE_OFS = 8'h18;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;
    localparam logic [7:0] RESULT_BASE_OFS = 8'h20;

    // field positions in the status, enable, disable and mask words
    localparam int EOC_LSB = 0;
    localparam int CHANNEL_OVERRUN_FLAG_LSB = 8;
    localparam int RESULT_AVAILABLE_FLAG_BIT = 16;
    localparam int GLOBAL_OVERRUN_FLAG_BIT = 17;
    localparam int RECEIVE_TRANSFER_END_FLAG_BIT = 18;
    localparam int RECEIVE_BUFFERS_EMPTY_FLAG_BIT = 19;

    // reset values
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 20'h00000;
    localparam logic [CHAN_N-1:0] CHAN_EN_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RESET = 10'h000;

    // bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // true for the eight channel result words
    function automatic logic is_result_addr(input logic [DEC_W-1:0] a);
        return (a[7:5] == RESULT_BASE_OFS[7:5]) && (a[1:0] == 2'h0);
    endfunction : is_result_addr

    // channel number of a result word
    function automatic logic [CHAN_W-1:0] result_index(
        input logic [DEC_W-1:0] a);
        return a[4:2];
    endfunction : result_index

endpackage : adc_irq_pkg

// ### rtl/sticky_flags.sv
// bank of sticky flags, set wins over clear
`timescale 1ns/1ns
module sticky_flags #(
    parameter int W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] flags
);

    // an event in the clearing cycle must not be lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clr) | set;
        end
    end

endmodule : sticky_flags

// ### rtl/result_memory.sv
// eight-word store of channel results with registered read data
`timescale 1ns/1ns
module result_memory
    import adc_irq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_en,
    input wire logic [CHAN_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [CHAN_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] mem [CHAN_N];

    // storage; reset so a never-converted channel reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CHAN_N; i++) begin
                mem[i] <= DATA_RESET;
            end
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read port; a same-cycle write is seen one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= DATA_RESET;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : result_memory

// ### test/conv_core_model.sv
// behavioural conversion core: completion pulses and receive events
`timescale 1ns/1ns
module conv_core_model
    import adc_irq_pkg::*;
(
    input wire logic hclk,
    output logic conv_done,
    output logic [CHAN_W-1:0] conv_channel,
    output logic [DATA_W-1:0] conv_value,
    output logic rx_count_zero,
    output logic rx_buffers_empty
);
    // quiet outputs from time zero
    initial begin
        conv_done = 1'b0;
        conv_channel = '0;
        conv_value = '0;
        rx_count_zero = 1'b0;
        rx_buffers_empty = 1'b0;
    end

    // one completion after gap idle cycles; channel and value are
    // inverted once the pulse ends, so a late sampler sees garbage
    task automatic convert(input logic [CHAN_W-1:0] ch,
        input logic [DATA_W-1:0] val, input int gap);
        repeat (gap) @(posedge hclk);
        conv_done <= 1'b1;
        conv_channel <= ch;
        conv_value <= val;
        @(posedge hclk);
        conv_done <= 1'b0;
        conv_channel <= ~ch;
        conv_value <= ~val;
    endtask : convert

    // receive counter reached zero, one-cycle pulse
    task automatic rx_end();
        rx_count_zero <= 1'b1;
        @(posedge hclk);
        rx_count_zero <= 1'b0;
    endtask : rx_end

    // both receive counters empty, a level
    task automatic set_empty(input logic lvl);
        rx_buffers_empty <= lvl;
        @(posedge hclk);
    endtask : set_empty

endmodule : conv_core_model

// ### test/adc_irq_regs_sva.sv
// assertion checker for the interrupt mask and result registers
`timescale 1ns/1ns
module adc_irq_regs_sva
    import adc_irq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic conv_done,
    input wire logic [CHAN_W-1:0] conv_channel,
    input wire logic [DATA_W-1:0] conv_value,
    input wire logic rx_count_zero,
    input wire logic rx_buffers_empty,
    input wire logic [CHAN_N-1:0] chan_enabled,
    input wire logic adc_irq
);
    logic take;
    logic ph_wr;
    logic [7:0] ph_ofs;
    logic [IRQ_W-1:0] mask;
    logic [DATA_W-1:0] res [CHAN_N];
    logic [DATA_W-1:0] exp_res;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    assign take = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);

    // address phase shadow; result expected is the pre-edge word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr <= 1'b0;
            ph_ofs <= 8'h00;
            exp_res <= '0;
        end else begin
            ph_wr <= take && hwrite;
            ph_ofs <= haddr[7:0];
            exp_res <= res[haddr[4:2]];
        end
    end

    // mask shadow, written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= '0;
        end else if (ph_wr && ph_ofs == IRQ_ENABLE_OFS) begin
            mask <= mask | hwdata[IRQ_W-1:0];
        end else if (ph_wr && ph_ofs == IRQ_DISABLE_OFS) begin
            mask <= mask & ~hwdata[IRQ_W-1:0];
        end
    end

    // result shadow, loaded by accepted completions only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CHAN_N; i++) res[i] <= '0;
        end else if (conv_done && chan_enabled[conv_channel]) begin
            res[conv_channel] <= conv_value;
        end
    end

    sequence s_rd(logic [7:0] ofs);
        take && !hwrite && haddr[7:0] == ofs;
    endsequence
    sequence s_rd_res;
        take && !hwrite && haddr[7:5] == 3'h1 && haddr[1:0] == 2'h0;
    endsequence
    sequence s_conv;
        conv_done && chan_enabled[conv_channel];
    endsequence

    a_mask_read: assert property (
        s_rd(IRQ_MASK_OFS) |=> hrdata == {12'h000, mask})
        else $error("mask read differs from written history");
    a_result_read: assert property (
        s_rd_res |=> hrdata == {22'h000000, exp_res})
        else $error("result word differs from last accepted value");
    a_done_gated: assert property (
        s_rd(STATUS_OFS) |=>
        (hrdata[7:0] & ~(chan_enabled | $past(chan_enabled))) == 8'h00)
        else $error("done flag shown for disabled channel");
    a_irq_masked: assert property (
        mask == 20'h00000 |-> !adc_irq)
        else $error("interrupt raised with all sources masked");
    a_avail_irq: assert property (
        s_conv |=> !mask[16] || adc_irq)
        else $error("result available did not raise interrupt");
    a_done_irq: assert property (
        s_conv |=> !(mask[$past(conv_channel)] &&
        chan_enabled[$past(conv_channel)]) || adc_irq)
        else $error("channel done did not raise interrupt");
    a_rxend_irq: assert property (
        rx_count_zero |=> !mask[18] || adc_irq)
        else $error("transfer end did not raise interrupt");
    a_rxempty_irq: assert property (
        (rx_buffers_empty && mask[19]) [*2] |-> adc_irq)
        else $error("buffers empty did not raise interrupt");
endmodule : adc_irq_regs_sva

bind adc_irq_regs adc_irq_regs_sva adc_irq_regs_sva_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .conv_done, .conv_channel,
    .conv_value, .rx_count_zero, .rx_buffers_empty, .chan_enabled,
    .adc_irq
);

// ### test/tb_adc_irq_regs.sv
// self-checking bench for the interrupt mask and result registers
`timescale 1ns/1ns
module tb_adc_irq_regs
    import adc_irq_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h00000000;
    wire logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic conv_done;
    logic [CHAN_W-1:0] conv_channel;
    logic [DATA_W-1:0] conv_value;
    logic rx_count_zero;
    logic rx_buffers_empty;
    logic [CHAN_N-1:0] chan_enabled;
    logic adc_irq;
    int n_errors = 0;
    int n_tests = 0;
    int b;
    logic [31:0] exp_word;

    always #5 hclk = ~hclk;

    adc_irq_regs adc_irq_regs_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .conv_done(conv_done), .conv_channel(conv_channel),
        .conv_value(conv_value), .rx_count_zero(rx_count_zero),
        .rx_buffers_empty(rx_buffers_empty),
        .chan_enabled(chan_enabled), .adc_irq(adc_irq));
    conv_core_model conv_core_model_inst (.hclk(hclk),
        .conv_done(conv_done), .conv_channel(conv_channel),
        .conv_value(conv_value), .rx_count_zero(rx_count_zero),
        .rx_buffers_empty(rx_buffers_empty));

    task automatic end_sim();
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask : check

    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int i;
        for (i = 0; i < 64; i++) begin
            @(posedge hclk);
            if (hready === 1'b1) break;
        end
        if (i == 64) begin
            n_errors++;
            end_sim();
        end
    endtask : wait_ready

    // one single transfer; entered just after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        check("hresp", 32'h00000000, {31'h00000000, hresp});
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h00000000, q);
        check($sformatf("read %h", a), exp, q);
    endtask : rd_chk

    // margin of two edges covers a registered status level
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        check("adc_irq", {31'h00000000, exp}, {31'h00000000, adc_irq});
        @(posedge hclk);
    endtask : irq_chk

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(IRQ_MASK_OFS, 32'h00000000);
        rd_chk(RESULT_BASE_OFS, 32'h00000000);
        wr(IRQ_ENABLE_OFS, 32'hFFFFFFFF);
        wr(IRQ_MASK_OFS, 32'h00000000);
        rd_chk(IRQ_MASK_OFS, 32'h000FFFFF);
        wr(IRQ_DISABLE_OFS, 32'h00000000);
        rd_chk(IRQ_MASK_OFS, 32'h000FFFFF);
        // clear one mask bit at a time, low to high
        for (b = 0; b < 20; b++) begin
            wr(IRQ_DISABLE_OFS, 32'h00000001 << b);
            exp_word = (32'h000FFFFF << (b + 1)) & 32'h000FFFFF;
            rd_chk(IRQ_MASK_OFS, exp_word);
        end
        // channels 0-3 enabled, 4-7 left off; completions one or two
        // idle cycles apart
        wr(CHAN_ENABLE_OFS, 32'h0000000F);
        wr(IRQ_ENABLE_OFS, 32'h00010001);
        for (b = 0; b < 8; b++) begin
            conv_core_model_inst.convert(b[2:0], {1'b1, b[2:0], 6'h2A},
                1 + b % 2);
        end
        irq_chk(1'b1);
        rd_chk(STATUS_OFS, 32'h0003000F);
        conv_core_model_inst.convert(3'h1, 10'h155, 0);
        rd_chk(STATUS_OFS, 32'h0003020F);
        rd_chk(STATUS_OFS, 32'h0001000F);
        rd_chk(LATEST_OFS, 32'h00000155);
        rd_chk(STATUS_OFS, 32'h0000000F);
        for (b = 0; b < 8; b++) begin
            exp_word = (b == 1) ? 32'h00000155
                : (b < 4) ? {22'h000000, 1'b1, b[2:0], 6'h2A} : 32'h00000000;
            rd_chk(8'(RESULT_BASE_OFS + 4 * b), exp_word);
        end
        rd_chk(STATUS_OFS, 32'h00000000);
        irq_chk(1'b0);
        // a disabled channel keeps its result and hides its done flag
        conv_core_model_inst.convert(3'h0, 10'h3C3, 1);
        wr(CHAN_DISABLE_OFS, 32'h00000001);
        rd_chk(CHAN_STATUS_OFS, 32'h0000000E);
        check("chan_enabled", 32'h0000000E, {24'h000000, chan_enabled});
        rd_chk(STATUS_OFS, 32'h00010000);
        conv_core_model_inst.convert(3'h0, 10'h0F0, 1);
        rd_chk(RESULT_BASE_OFS, 32'h000003C3);
        rd_chk(LATEST_OFS, 32'h000003C3);
        wr(IRQ_ENABLE_OFS, 32'h000C0000);
        conv_core_model_inst.rx_end();
        irq_chk(1'b1);
        rd_chk(STATUS_OFS, 32'h00040000);
        irq_chk(1'b0);
        conv_core_model_inst.set_empty(1'b1);
        irq_chk(1'b1);
        wr(IRQ_DISABLE_OFS, 32'h00080000);
        irq_chk(1'b0);
        end_sim();
    end
endmodule : tb_adc_irq_regs
